// File: src/usart_ctrl_pkg.sv
package usart_ctrl_pkg;

  // ==========================================================
  // Bus geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  // ==========================================================
  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_INT_MODE = 4'h5;
  localparam logic [ADDR_W-1:0] OFS_RXTX = 4'h6;
  localparam logic [ADDR_W-1:0] OFS_FORMAT = 4'h7;

  // ==========================================================
  // Values after reset and implemented-bit masks
  localparam logic [DATA_W-1:0] RST_INT_MODE = 8'h00;
  localparam logic [DATA_W-1:0] RST_RXTX = 8'h00;
  localparam logic [DATA_W-1:0] RST_FORMAT = 8'h03;
  localparam logic [DATA_W-1:0] RST_RDATA = 8'h00;
  localparam logic [DATA_W-1:0] MASK_INT_MODE = 8'hFD;
  localparam logic [DATA_W-1:0] MASK_RXTX = 8'hDF;
  localparam logic [DATA_W-1:0] MASK_FORMAT = 8'hFF;
  localparam logic [DATA_W-1:0] MASK_FORMAT_SPI = 8'hC6;

  // ==========================================================
  // Interrupt and mode control fields
  localparam int A_RX_DONE_IE = 7;
  localparam int A_TX_DONE_IE = 6;
  localparam int A_TX_EMPTY_IE = 5;
  localparam int A_RX_START_IE = 4;
  localparam int A_LOOPBACK = 3;
  localparam int A_AUTOBAUD_IE = 2;
  localparam int A_RS485 = 0;

  // ==========================================================
  // Receiver and transmitter enable control fields
  localparam int B_RX_EN = 7;
  localparam int B_TX_EN = 6;
  localparam int B_FRAME_DET = 4;
  localparam int B_OPEN_DRAIN = 3;
  localparam int B_RX_MODE_LSB = 1;
  localparam int B_MULTIPROC = 0;

  // ==========================================================
  // Frame format control fields
  localparam int C_COMMUNICATION_MODE_LSB = 6;
  localparam int C_PARITY_LSB = 4;
  localparam int C_STOP = 3;
  localparam int C_CHARACTER_SIZE_LSB = 0;
  localparam int C_SPI_ORDER = 2;
  localparam int C_SPI_PHASE = 1;

  // ==========================================================
  // Status fields
  localparam int S_RX_DONE = 7;
  localparam int S_TX_DONE = 6;
  localparam int S_TX_EMPTY = 5;
  localparam int S_RX_START = 4;
  localparam int S_BAD_SYNC = 3;
  localparam int S_BREAK_WAIT = 0;

  // ==========================================================
  // Field codes
  localparam logic [1:0] COMMUNICATION_MODE_ASYNC = 2'h0;
  localparam logic [1:0] COMMUNICATION_MODE_SYNC = 2'h1;
  localparam logic [1:0] COMMUNICATION_MODE_INFRARED = 2'h2;
  localparam logic [1:0] COMMUNICATION_MODE_HOST_SPI = 2'h3;
  localparam logic [1:0] RECEIVER_SPEED_MODE_NORMAL = 2'h0;
  localparam logic [1:0] RECEIVER_SPEED_MODE_DOUBLE = 2'h1;
  localparam logic [1:0] RECEIVER_SPEED_MODE_GENERIC_AB = 2'h2;
  localparam logic [1:0] RECEIVER_SPEED_MODE_LIN_AB = 2'h3;
  localparam logic [1:0] PARITY_NONE = 2'h0;
  localparam logic [1:0] PARITY_RSVD = 2'h1;
  localparam logic [1:0] PARITY_EVEN = 2'h2;
  localparam logic [1:0] PARITY_ODD = 2'h3;
  localparam logic [2:0] CHARACTER_SIZE_5 = 3'h0;
  localparam logic [2:0] CHARACTER_SIZE_6 = 3'h1;
  localparam logic [2:0] CHARACTER_SIZE_7 = 3'h2;
  localparam logic [2:0] CHARACTER_SIZE_8 = 3'h3;
  localparam logic [2:0] CHARACTER_SIZE_9_LOW = 3'h6;
  localparam logic [2:0] CHARACTER_SIZE_9_HIGH = 3'h7;

  // ==========================================================
  // Decoded data bit counts
  localparam logic [3:0] BITS_5 = 4'h5;
  localparam logic [3:0] BITS_6 = 4'h6;
  localparam logic [3:0] BITS_7 = 4'h7;
  localparam logic [3:0] BITS_8 = 4'h8;
  localparam logic [3:0] BITS_9 = 4'h9;

  // Idle level of the serial line
  localparam logic LINE_IDLE = 1'b1;

endpackage

// File: src/pin_sync.sv
`timescale 1ns/1ps
module pin_sync
  import usart_ctrl_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic pin_i,
  output logic level_o
);
  import usart_ctrl_pkg::*;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } sync_state_t;

  sync_state_t st_r;
  sync_state_t st_nxt;

  // ==========================================================
  // Three stage chain, change taken when stages two and three agree
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.s1 = pin_i;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    if (st_r.s2 == st_r.s3)
    begin
      st_nxt.level = st_r.s3;
    end
  end

  // State register
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st_r <= {LINE_IDLE, LINE_IDLE, LINE_IDLE, LINE_IDLE};
    end
    else if (ce_i)
    begin
      st_r <= st_nxt;
    end
  end

  assign level_o = st_r.level;

endmodule // pin_sync

// File: src/format_decode.sv
`timescale 1ns/1ps
module format_decode
  import usart_ctrl_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [usart_ctrl_pkg::DATA_W-1:0] format_i,
  output logic [1:0] comm_mode_o,
  output logic host_spi_mode_o,
  output logic parity_enable_o,
  output logic parity_odd_o,
  output logic tx_two_stop_o,
  output logic [3:0] data_bits_o,
  output logic nine_low_first_o,
  output logic spi_lsb_first_o,
  output logic spi_sample_trailing_o
);
  import usart_ctrl_pkg::*;

  typedef struct packed {
    logic [1:0] communication_mode;
    logic spi;
    logic par_en;
    logic par_odd;
    logic two_stop;
    logic [3:0] bits;
    logic low_first;
    logic spi_lsb;
    logic spi_trail;
  } dec_state_t;

  dec_state_t st_r;
  dec_state_t st_nxt;
  logic [1:0] parity;
  logic [2:0] character_size;

  assign parity = format_i[C_PARITY_LSB+:2];
  assign character_size = format_i[C_CHARACTER_SIZE_LSB+:3];

  // ==========================================================
  // Field decode, layout chosen by communication mode
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.communication_mode = format_i[C_COMMUNICATION_MODE_LSB+:2];
    st_nxt.spi = (st_nxt.communication_mode == COMMUNICATION_MODE_HOST_SPI);
    st_nxt.par_en = 1'b0;
    st_nxt.par_odd = 1'b0;
    st_nxt.two_stop = 1'b0;
    st_nxt.bits = BITS_8;
    st_nxt.low_first = 1'b0;
    st_nxt.spi_lsb = 1'b0;
    st_nxt.spi_trail = 1'b0;
    if (st_nxt.spi)
    begin
      // Host SPI layout of the same bits
      st_nxt.spi_lsb = format_i[C_SPI_ORDER];
      st_nxt.spi_trail = format_i[C_SPI_PHASE];
    end
    else
    begin
      // Reserved parity code acts as no parity
      st_nxt.par_en = (parity == PARITY_EVEN) || (parity == PARITY_ODD);
      st_nxt.par_odd = (parity == PARITY_ODD);
      st_nxt.two_stop = format_i[C_STOP];
      case (character_size)
        CHARACTER_SIZE_5: st_nxt.bits = BITS_5;
        CHARACTER_SIZE_6: st_nxt.bits = BITS_6;
        CHARACTER_SIZE_7: st_nxt.bits = BITS_7;
        CHARACTER_SIZE_8: st_nxt.bits = BITS_8;
        CHARACTER_SIZE_9_LOW:
        begin
          st_nxt.bits = BITS_9;
          st_nxt.low_first = 1'b1;
        end
        CHARACTER_SIZE_9_HIGH: st_nxt.bits = BITS_9;
        default: st_nxt.bits = BITS_8;
      endcase
    end
  end

  // State register
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st_r <= {COMMUNICATION_MODE_ASYNC, 1'b0, 1'b0, 1'b0, 1'b0, BITS_8, 1'b0, 1'b0, 1'b0};
    end
    else if (ce_i)
    begin
      st_r <= st_nxt;
    end
  end

  assign comm_mode_o = st_r.communication_mode;
  assign host_spi_mode_o = st_r.spi;
  assign parity_enable_o = st_r.par_en;
  assign parity_odd_o = st_r.par_odd;
  assign tx_two_stop_o = st_r.two_stop;
  assign data_bits_o = st_r.bits;
  assign nine_low_first_o = st_r.low_first;
  assign spi_lsb_first_o = st_r.spi_lsb;
  assign spi_sample_trailing_o = st_r.spi_trail;

endmodule // format_decode

// File: src/usart_control_config.sv
// Local design decision: strobed register access.
`timescale 1ns/1ps
module usart_control_config
  import usart_ctrl_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [usart_ctrl_pkg::ADDR_W-1:0] addr_i,
  input wire logic [usart_ctrl_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [usart_ctrl_pkg::DATA_W-1:0] rdata_o,
  input wire logic rx_done_flag_i,
  input wire logic tx_done_flag_i,
  input wire logic tx_buffer_empty_flag_i,
  input wire logic rx_start_flag_i,
  input wire logic bad_sync_field_flag_i,
  input wire logic frame_handled_i,
  output logic break_wait_arm_o,
  output logic rx_done_irq_o,
  output logic tx_done_irq_o,
  output logic tx_buffer_empty_irq_o,
  output logic rx_start_irq_o,
  output logic autobaud_error_irq_o,
  input wire logic rxd_i,
  input wire logic tx_serial_i,
  output logic rx_serial_o,
  output logic txd_o,
  output logic txd_oe_o,
  output logic rs485_enable_o,
  output logic receiver_enable_o,
  output logic transmitter_enable_o,
  output logic frame_start_detect_enable_o,
  output logic open_drain_enable_o,
  output logic [1:0] receiver_speed_mode_o,
  output logic double_speed_o,
  output logic generic_autobaud_o,
  output logic lin_constrained_autobaud_o,
  output logic multiprocessor_mode_o,
  output logic [1:0] communication_mode_o,
  output logic host_spi_mode_o,
  output logic parity_enable_o,
  output logic parity_odd_o,
  output logic tx_two_stop_o,
  output logic [3:0] data_bits_o,
  output logic nine_low_first_o,
  output logic spi_lsb_first_o,
  output logic spi_sample_trailing_o
);
  import usart_ctrl_pkg::*;

  // ==========================================================
  // State
  typedef struct packed {
    logic [DATA_W-1:0] int_mode;
    logic [DATA_W-1:0] rxtx;
    logic [DATA_W-1:0] format;
    logic break_wait;
    logic [DATA_W-1:0] rdata;
    logic [4:0] irq;
    logic rx_line;
    logic txd;
    logic txd_oe;
  } ctrl_state_t;

  ctrl_state_t st_r;
  ctrl_state_t st_nxt;
  logic rxd_level;
  logic [4:0] flags;
  logic [4:0] enables;
  logic [DATA_W-1:0] status_view;
  logic [DATA_W-1:0] read_mux;
  logic [DATA_W-1:0] format_mask;

  // ==========================================================
  // Receive pin synchroniser
  pin_sync u_rxd_sync (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .pin_i(rxd_i),
    .level_o(rxd_level)
  );

  // ==========================================================
  // Flag and enable vectors, same bit order
  assign flags = {rx_done_flag_i, tx_done_flag_i, tx_buffer_empty_flag_i,
                  rx_start_flag_i, bad_sync_field_flag_i};
  assign enables = {st_r.int_mode[A_RX_DONE_IE],
                    st_r.int_mode[A_TX_DONE_IE],
                    st_r.int_mode[A_TX_EMPTY_IE],
                    st_r.int_mode[A_RX_START_IE],
                    st_r.int_mode[A_AUTOBAUD_IE]};

  // Status view, break wait bit is write only
  always_comb
  begin
    status_view = '0;
    status_view[S_RX_DONE] = rx_done_flag_i;
    status_view[S_TX_DONE] = tx_done_flag_i;
    status_view[S_TX_EMPTY] = tx_buffer_empty_flag_i;
    status_view[S_RX_START] = rx_start_flag_i;
    status_view[S_BAD_SYNC] = bad_sync_field_flag_i;
  end

  // Format write mask depends on the mode being written
  assign format_mask = (wdata_i[C_COMMUNICATION_MODE_LSB+:2] == COMMUNICATION_MODE_HOST_SPI) ?
                       MASK_FORMAT_SPI : MASK_FORMAT;

  // ==========================================================
  // Read multiplexer, unmapped offsets read zero
  always_comb
  begin
    case (addr_i)
      OFS_STATUS: read_mux = status_view;
      OFS_INT_MODE: read_mux = st_r.int_mode & MASK_INT_MODE;
      OFS_RXTX: read_mux = st_r.rxtx & MASK_RXTX;
      OFS_FORMAT: read_mux = st_r.format;
      default: read_mux = '0;
    endcase
  end

  // ==========================================================
  // Next state
  always_comb
  begin
    st_nxt = st_r;
    // Read data stand only in the cycle after the strobe
    st_nxt.rdata = rd_i ? read_mux : RST_RDATA;
    // Control register writes, unused bits dropped
    if (wr_i && (addr_i == OFS_INT_MODE))
    begin
      st_nxt.int_mode = wdata_i & MASK_INT_MODE;
    end
    if (wr_i && (addr_i == OFS_RXTX))
    begin
      st_nxt.rxtx = wdata_i & MASK_RXTX;
    end
    if (wr_i && (addr_i == OFS_FORMAT))
    begin
      st_nxt.format = wdata_i & format_mask;
    end
    // Break wait: frame end clears, a new arm wins over it
    if (frame_handled_i)
    begin
      st_nxt.break_wait = 1'b0;
    end
    if (wr_i && (addr_i == OFS_STATUS) && wdata_i[S_BREAK_WAIT])
    begin
      st_nxt.break_wait = 1'b1;
    end
    // Interrupt levels
    st_nxt.irq = flags & enables;
    // Receiver input source
    st_nxt.rx_line = st_r.int_mode[A_LOOPBACK] ? tx_serial_i : rxd_level;
    // Transmit pin drive
    if (st_r.rxtx[B_OPEN_DRAIN])
    begin
      st_nxt.txd = 1'b0;
      st_nxt.txd_oe = st_r.rxtx[B_TX_EN] & ~tx_serial_i;
    end
    else
    begin
      st_nxt.txd = tx_serial_i;
      st_nxt.txd_oe = st_r.rxtx[B_TX_EN];
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st_r <= {RST_INT_MODE, RST_RXTX, RST_FORMAT, 1'b0, RST_RDATA, 5'h00,
               LINE_IDLE, LINE_IDLE, 1'b0};
    end
    else if (ce_i)
    begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // Frame format decode
  format_decode u_format (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .format_i(st_r.format),
    .comm_mode_o(communication_mode_o),
    .host_spi_mode_o(host_spi_mode_o),
    .parity_enable_o(parity_enable_o),
    .parity_odd_o(parity_odd_o),
    .tx_two_stop_o(tx_two_stop_o),
    .data_bits_o(data_bits_o),
    .nine_low_first_o(nine_low_first_o),
    .spi_lsb_first_o(spi_lsb_first_o),
    .spi_sample_trailing_o(spi_sample_trailing_o)
  );

  // ==========================================================
  // Outputs
  assign rdata_o = st_r.rdata;
  assign break_wait_arm_o = st_r.break_wait;
  assign {rx_done_irq_o, tx_done_irq_o, tx_buffer_empty_irq_o,
          rx_start_irq_o, autobaud_error_irq_o} = st_r.irq;
  assign rx_serial_o = st_r.rx_line;
  assign txd_o = st_r.txd;
  assign txd_oe_o = st_r.txd_oe;

  // Control bit outputs
  assign rs485_enable_o = st_r.int_mode[A_RS485];
  assign receiver_enable_o = st_r.rxtx[B_RX_EN];
  assign transmitter_enable_o = st_r.rxtx[B_TX_EN];
  assign frame_start_detect_enable_o = st_r.rxtx[B_FRAME_DET];
  assign open_drain_enable_o = st_r.rxtx[B_OPEN_DRAIN];
  assign multiprocessor_mode_o = st_r.rxtx[B_MULTIPROC];

  // Receiver speed mode decode
  assign receiver_speed_mode_o = st_r.rxtx[B_RX_MODE_LSB+:2];
  assign double_speed_o = (receiver_speed_mode_o == RECEIVER_SPEED_MODE_DOUBLE);
  assign generic_autobaud_o =
    (receiver_speed_mode_o == RECEIVER_SPEED_MODE_GENERIC_AB);
  assign lin_constrained_autobaud_o =
    (receiver_speed_mode_o == RECEIVER_SPEED_MODE_LIN_AB);

  // ==========================================================
  // Checks
  sequence arm_write_s;
    ce_i && wr_i && (addr_i == OFS_STATUS) && wdata_i[S_BREAK_WAIT];
  endsequence

  sequence frame_end_s;
    ce_i && frame_handled_i && !(wr_i && (addr_i == OFS_STATUS)
                                 && wdata_i[S_BREAK_WAIT]);
  endsequence

  AST_BREAK_ARM: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    arm_write_s |=> break_wait_arm_o)
    else $error("break wait not armed");

  AST_BREAK_CLEAR: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    frame_end_s |=> !break_wait_arm_o)
    else $error("break wait not cleared after frame");

  AST_RX_DONE_IRQ: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    ce_i |=> rx_done_irq_o ==
      $past(rx_done_flag_i && st_r.int_mode[A_RX_DONE_IE]))
    else $error("receive done interrupt wrong");

  AST_TX_DONE_IRQ: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    ce_i |=> tx_done_irq_o ==
      $past(tx_done_flag_i && st_r.int_mode[A_TX_DONE_IE]))
    else $error("transmit done interrupt wrong");

  AST_TX_EMPTY_IRQ: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    ce_i |=> tx_buffer_empty_irq_o ==
      $past(tx_buffer_empty_flag_i && st_r.int_mode[A_TX_EMPTY_IE]))
    else $error("buffer empty interrupt wrong");

  AST_RX_START_IRQ: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    ce_i |=> rx_start_irq_o ==
      $past(rx_start_flag_i && st_r.int_mode[A_RX_START_IE]))
    else $error("receive start interrupt wrong");

  AST_AUTOBAUD_IRQ: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    ce_i |=> autobaud_error_irq_o ==
      $past(bad_sync_field_flag_i && st_r.int_mode[A_AUTOBAUD_IE]))
    else $error("autobaud error interrupt wrong");

  AST_LOOPBACK: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    ce_i && st_r.int_mode[A_LOOPBACK] |=> rx_serial_o == $past(tx_serial_i))
    else $error("loopback source wrong");

  AST_OPEN_DRAIN: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    ce_i && st_r.rxtx[B_OPEN_DRAIN] && tx_serial_i |=> !txd_oe_o && !txd_o)
    else $error("open drain drives high");

  AST_UNUSED_ZERO: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    ce_i && rd_i && (addr_i == OFS_RXTX) |=> !rdata_o[5])
    else $error("unused bit reads one");

  // Status read shows the receive done, buffer empty and bad sync flag levels, arm bit reads zero
  AST_STATUS_READ: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    ce_i && rd_i && (addr_i == OFS_STATUS) |=>
      (rdata_o[S_RX_DONE] == $past(rx_done_flag_i)) &&
      (rdata_o[S_TX_EMPTY] == $past(tx_buffer_empty_flag_i)) &&
      (rdata_o[S_BAD_SYNC] == $past(bad_sync_field_flag_i)) &&
      !rdata_o[S_BREAK_WAIT])
    else $error("status read wrong");

  // Armed break wait holds until a frame is handled
  AST_BREAK_HOLD: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    ce_i && break_wait_arm_o && !frame_handled_i |=> break_wait_arm_o)
    else $error("break wait dropped early");

  // RS-485 bit follows the written value
  AST_RS485: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    ce_i && wr_i && (addr_i == OFS_INT_MODE) |=>
      rs485_enable_o == $past(wdata_i[A_RS485]))
    else $error("rs485 enable wrong");

  // Receiver and transmitter enables follow the written value
  AST_RX_TX_EN: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    ce_i && wr_i && (addr_i == OFS_RXTX) |=>
      (receiver_enable_o == $past(wdata_i[B_RX_EN])) &&
      (transmitter_enable_o == $past(wdata_i[B_TX_EN])))
    else $error("receiver or transmitter enable wrong");

  // Frame start detect and multiprocessor bits follow the write
  AST_DET_MULTIPROC: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    ce_i && wr_i && (addr_i == OFS_RXTX) |=>
      (frame_start_detect_enable_o == $past(wdata_i[B_FRAME_DET])) &&
      (multiprocessor_mode_o == $past(wdata_i[B_MULTIPROC])))
    else $error("frame detect or multiprocessor bit wrong");

endmodule // usart_control_config

// File: bench/remote_node.sv
`timescale 1ns/1ps
module remote_node
(
  input wire logic core_clk_i,
  input wire logic txd_i,
  input wire logic txd_oe_i,
  output logic rxd_o,
  output logic line_o
);
  // ==========================================================
  // Line seen by the far node, pull-up when released
  assign line_o = txd_oe_i ? txd_i : 1'b1;

  // Idle receive pin at time zero
  initial rxd_o = 1'b1;

  // Drive one level onto the receive pin just after an edge
  task automatic send(input logic b);
    @(posedge core_clk_i);
    rxd_o <= b;
  endtask
endmodule // remote_node

// File: bench/usart_control_config_tb_top.sv
`timescale 1ns/1ps
module usart_control_config_tb_top;
  import usart_ctrl_pkg::*;
  // ==========================================================
  // Signals
  logic clk, rst_n, ce, wr, rd, fh, txs, rxd, rxs, txd, oe, line, arm;
  logic [3:0] addr, nb;
  logic [7:0] wdata, rdata, v;
  logic [4:0] fl, irq, fm;
  logic [5:0] en;
  logic [1:0] spd, cm, spi;
  logic [2:0] sd;
  logic [2:0] cs[7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7, 3'h4};
  logic [3:0] nbx[7] = '{4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'h9, 4'h8};
  logic [2:0] oexp[4] = '{3'b010, 3'b001, 3'b010, 3'b111};
  int pos[5] = '{2, 4, 5, 6, 7};
  int err_count, total_checks;

  // ==========================================================
  // Design and far node
  usart_control_config i_dut (
    .core_clk_i(clk), .rst_n_i(rst_n), .ce_i(ce), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .rx_done_flag_i(fl[4]), .tx_done_flag_i(fl[3]),
    .tx_buffer_empty_flag_i(fl[2]), .rx_start_flag_i(fl[1]),
    .bad_sync_field_flag_i(fl[0]), .frame_handled_i(fh),
    .break_wait_arm_o(arm), .rx_done_irq_o(irq[4]),
    .tx_done_irq_o(irq[3]), .tx_buffer_empty_irq_o(irq[2]),
    .rx_start_irq_o(irq[1]), .autobaud_error_irq_o(irq[0]),
    .rxd_i(rxd), .tx_serial_i(txs), .rx_serial_o(rxs), .txd_o(txd),
    .txd_oe_o(oe), .rs485_enable_o(en[0]), .receiver_enable_o(en[5]),
    .transmitter_enable_o(en[4]), .frame_start_detect_enable_o(en[3]),
    .open_drain_enable_o(en[2]), .receiver_speed_mode_o(spd),
    .double_speed_o(sd[2]), .generic_autobaud_o(sd[1]),
    .lin_constrained_autobaud_o(sd[0]), .multiprocessor_mode_o(en[1]),
    .communication_mode_o(cm), .host_spi_mode_o(fm[4]),
    .parity_enable_o(fm[3]), .parity_odd_o(fm[2]),
    .tx_two_stop_o(fm[1]), .data_bits_o(nb), .nine_low_first_o(fm[0]),
    .spi_lsb_first_o(spi[1]), .spi_sample_trailing_o(spi[0])
  );
  remote_node i_node (
    .core_clk_i(clk), .txd_i(txd), .txd_oe_i(oe), .rxd_o(rxd),
    .line_o(line)
  );

  // ==========================================================
  // Clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Compare and count
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask

  // Let n edges pass, then settle
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // One-cycle register write
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // One-cycle read, data checked in the following cycle
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask

  // Verdict and end of run
  task automatic print_verdict();
    $display("Checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Watchdog
  initial
  begin
    #100us;
    err_count++;
    print_verdict();
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    rst_n = 1'b0;
    ce = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    fh = 1'b0;
    txs = 1'b1;
    fl = 5'h00;
    addr = 4'h0;
    wdata = 8'h00;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    // Reset values, unmapped place, unused bits
    rd_chk(4'h5, 8'h00);
    rd_chk(4'h6, 8'h00);
    rd_chk(4'h7, 8'h03);
    chk(nb, 8'h08);
    rd_chk(4'h0, 8'h00);
    wr_reg(4'h5, 8'hFF);
    rd_chk(4'h5, 8'hFD);
    wr_reg(4'h6, 8'hF9);
    rd_chk(4'h6, 8'hD9);
    chk(en, 8'h3F);
    wr_reg(4'h6, 8'h00);
    wr_reg(4'h5, 8'h00);
    cyc(1);
    chk(en, 8'h00);
    // Clock enable low drops a write
    @(posedge clk);
    ce <= 1'b0;
    wr_reg(4'h5, 8'h80);
    @(posedge clk);
    ce <= 1'b1;
    rd_chk(4'h5, 8'h00);
    // Interrupt levels, one flag at a time, then one enable at a time
    wr_reg(4'h5, 8'hF4);
    for (int k = 0; k < 5; k++)
    begin
      @(posedge clk);
      fl <= 5'h01 << k;
      cyc(2);
      chk(irq, 8'h01 << k);
    end
    @(posedge clk);
    fl <= 5'h1F;
    for (int k = 0; k < 5; k++)
    begin
      wr_reg(4'h5, 8'h01 << pos[k]);
      cyc(2);
      chk(irq, 8'h01 << k);
    end
    rd_chk(4'h4, 8'hF8);
    wr_reg(4'h5, 8'h00);
    cyc(2);
    chk(irq, 8'h00);
    // Loopback follows transmit bit, pin ignored until it is off
    wr_reg(4'h5, 8'h08);
    i_node.send(1'b1);
    txs <= 1'b0;
    cyc(2);
    chk(rxs, 8'h00);
    i_node.send(1'b0);
    txs <= 1'b1;
    cyc(2);
    chk(rxs, 8'h01);
    wr_reg(4'h5, 8'h00);
    cyc(6);
    chk(rxs, 8'h00);
    // Open drain then normal drive
    for (int j = 0; j < 2; j++)
    begin
      wr_reg(4'h6, j ? 8'h40 : 8'h48);
      for (int b = 0; b < 2; b++)
      begin
        @(posedge clk);
        txs <= b[0];
        cyc(2);
        chk({txd, oe, line}, oexp[j * 2 + b]);
      end
    end
    // Frame format codes
    for (int i = 0; i < 7; i++)
    begin
      v = {2'(i % 3), 2'(i % 4), i[0], cs[i]};
      wr_reg(4'h7, v);
      cyc(2);
      rd_chk(4'h7, v);
      chk(cm, v[7:6]);
      chk(fm, {1'b0, v[5], v[5:4] == 2'h3, v[3], cs[i] == 3'h6});
      chk(nb, nbx[i]);
    end
    // Host SPI layout
    wr_reg(4'h7, 8'hFF);
    cyc(2);
    rd_chk(4'h7, 8'hC6);
    chk({cm, spi}, {2'h3, 2'h3});
    chk(fm, 5'h10);
    chk(nb, 8'h08);
    // Receiver speed modes, synchronous line first
    wr_reg(4'h7, 8'h43);
    for (int m = 0; m < 4; m++)
    begin
      wr_reg(4'h6, 8'(m << 1));
      cyc(2);
      chk({spd, sd}, {2'(m), m == 1, m == 2, m == 3});
    end
    wr_reg(4'h6, 8'h00);
    // Break wait holds until one frame is handled
    wr_reg(4'h4, 8'h01);
    cyc(3);
    chk(arm, 8'h01);
    rd_chk(4'h4, 8'hF8);
    @(posedge clk);
    fh <= 1'b1;
    @(posedge clk);
    fh <= 1'b0;
    cyc(1);
    chk(arm, 8'h00);
    // Arm and frame end in one cycle: the arm wins
    @(posedge clk);
    fh <= 1'b1;
    wr <= 1'b1;
    addr <= 4'h4;
    wdata <= 8'h01;
    @(posedge clk);
    fh <= 1'b0;
    wr <= 1'b0;
    cyc(1);
    chk(arm, 8'h01);
    print_verdict();
  end
endmodule // usart_control_config_tb_top
